//--- common/card_uart_pkg.sv
// Constants and types shared by the card UART mixed status block
package card_uart_pkg;

  // ------------------------------------------------------------------
  // Bus and register map (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam int unsigned APB_AW           = 8;
  localparam int unsigned APB_DW           = 32;
  localparam int unsigned IDX_W            = APB_AW - 2;
  localparam logic [IDX_W-1:0] IDX_QUEUE_CTRL   = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_MIXED_STATUS = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_HOLDING      = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_CONTROL      = 6'h10;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS   = 6'h11;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE   = 6'h12;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR    = 6'h13;

  // ------------------------------------------------------------------
  // Field layouts
  // ------------------------------------------------------------------
  localparam int unsigned CHAR_W           = 8;
  localparam int unsigned MS_CLOCK_SWITCH_DONE         = 7;
  localparam int unsigned MS_EMPTY         = 6;
  localparam int unsigned MS_BGT           = 5;
  localparam int unsigned MS_PRESENT       = 2;
  localparam int unsigned MS_TXRX          = 0;
  localparam int unsigned QC_PEL_LSB       = 4;
  localparam int unsigned QC_DEPTH_LSB     = 0;
  localparam int unsigned QC_FIELD_W       = 3;
  localparam logic [QC_FIELD_W-1:0] QC_RESET = 3'h0;
  localparam int unsigned CTL_RUN          = 0;
  localparam int unsigned CTL_T1           = 1;
  localparam int unsigned CTL_LCT          = 2;
  localparam int unsigned CTL_CLKREQ       = 3;
  localparam int unsigned IRQ_PARITY       = 0;
  localparam int unsigned IRQ_OVERRUN      = 1;
  localparam int unsigned IRQ_W            = 2;

  // ------------------------------------------------------------------
  // Timing counts in ETU and queue sizing
  // ------------------------------------------------------------------
  localparam int unsigned ETU_CNT_W        = 5;
  localparam logic [ETU_CNT_W-1:0] BGT_ETU_T1 = 5'h16;
  localparam logic [ETU_CNT_W-1:0] BGT_ETU_T0 = 5'h10;
  localparam int unsigned FRAME_CNT_W      = 4;
  localparam logic [FRAME_CNT_W-1:0] CHAR_ETU = 4'hA;
  localparam int unsigned FIFO_DEPTH       = 8;
  localparam int unsigned CNT_W            = QC_FIELD_W + 1;

endpackage

//--- common/rx_queue_if.sv
// Connection between the status logic and the receive queue
`timescale 1ns/10ps

interface rx_queue_if;
  logic       push;
  logic [7:0] push_data;
  logic       pop;
  logic       flush;
  logic [2:0] depth_sel;
  logic [7:0] head_data;
  logic       empty;
  logic       full;

  modport ctrl (
    output push,
    output push_data,
    output pop,
    output flush,
    output depth_sel,
    input  head_data,
    input  empty,
    input  full
  );

  modport queue (
    input  push,
    input  push_data,
    input  pop,
    input  flush,
    input  depth_sel,
    output head_data,
    output empty,
    output full
  );
endinterface

//--- design/card_uart_mixed_status.sv
// Mixed status, queue control and APB register file of the card UART
//
// Behaviour
// - Clock switch flag follows completed switches
// - Run bit clear clears clock switch flag
// - Empty flag high while receive queue empty
// - Protocol one guard counts 22 ETU
// - Protocol zero guard counts 16 ETU
// - Present flag mirrors card presence contact
// - Tx empty flag set on three events
// - No set after clean last character
// - Tx empty flag cleared by four events
// - Tx to rx mode change clears flag
// - Write-only queue control fields, reset zero
// - Mixed status flags never drive interrupt
// - Queue depth is field value plus one
// - Parity limit is field value plus one
`timescale 1ns/10ps

module card_uart_mixed_status #(
  parameter int unsigned QUEUE_DEPTH = card_uart_pkg::FIFO_DEPTH
) (
  input  wire logic                               SYS_CLK_IN,
  input  wire logic                               RST_IN,
  input  wire logic                               PSEL_IN,
  input  wire logic                               PENABLE_IN,
  input  wire logic                               PWRITE_IN,
  input  wire logic [card_uart_pkg::APB_AW-1:0]   PADDR_IN,
  input  wire logic [card_uart_pkg::APB_DW-1:0]   PWDATA_IN,
  output logic      [card_uart_pkg::APB_DW-1:0]   PRDATA_OUT,
  output logic                                    PREADY_OUT,
  output logic                                    PSLVERR_OUT,
  output logic                                    IRQ_OUT,
  input  wire logic                               ETU_TICK_IN,
  input  wire logic                               CARD_IO_IN,
  input  wire logic                               CARD_PRESENT_IN,
  input  wire logic                               RX_VALID_IN,
  input  wire logic [card_uart_pkg::CHAR_W-1:0]   RX_CHAR_IN,
  input  wire logic                               RX_PARITY_ERR_IN,
  input  wire logic                               TX_DONE_IN,
  input  wire logic                               TX_PARITY_OK_IN,
  input  wire logic                               TX_MODE_IN,
  input  wire logic                               CLK_HALF_ACTIVE_IN,
  output logic                                    TX_LOAD_OUT,
  output logic      [card_uart_pkg::CHAR_W-1:0]   TX_DATA_OUT,
  output logic                                    UART_RUN_OUT,
  output logic                                    PROTOCOL_T1_OUT,
  output logic                                    LCT_MODE_OUT,
  output logic                                    CLK_SWITCH_REQ_OUT
);
  import card_uart_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                   io_meta;
    logic                   io_sync;
    logic                   io_prev;
    logic                   pres_meta;
    logic                   pres_sync;
    logic                   run;
    logic                   t1;
    logic                   last_char_transmit_mode;
    logic                   clk_req;
    logic [QC_FIELD_W-1:0]  perr_limit;
    logic [QC_FIELD_W-1:0]  depth_sel;
    logic [QC_FIELD_W-1:0]  perr_cnt;
    logic                   clk_sw_done;
    logic                   half_prev;
    logic                   tx_mode_prev;
    logic                   full_prev;
    logic                   txrx_flag;
    logic                   bgt_flag;
    logic                   bgt_run;
    logic [ETU_CNT_W-1:0]   bgt_cnt;
    logic                   in_frame;
    logic [FRAME_CNT_W-1:0] frame_cnt;
    logic [IRQ_W-1:0]       irq_st;
    logic [IRQ_W-1:0]       irq_en;
    logic                   irq;
    logic                   pready;
    logic                   pslverr;
    logic [CHAR_W-1:0]      rdata;
    logic                   tx_load;
    logic [CHAR_W-1:0]      tx_data;
  } state_t;

  state_t            q;
  state_t            n;
  rx_queue_if        q_if ();

  logic [IDX_W-1:0]  idx;
  logic              setup;
  logic              done;
  logic              wr;
  logic              rd;
  logic              wr_ctl;
  logic              wr_qc;
  logic              wr_tx;
  logic              rd_rx;
  logic              run_fall;
  logic              store;
  logic              perr_hit;
  logic              overrun;
  logic              txrx_set;
  logic              txrx_clr;
  logic              start_bit;
  logic [IRQ_W-1:0]  clr_mask;
  logic [CHAR_W-1:0] mixed;
  logic [CHAR_W-1:0] rd_val;

  function automatic logic mapped(input logic [IDX_W-1:0] i);
    case (i)
      IDX_MIXED_STATUS,
      IDX_HOLDING,
      IDX_CONTROL,
      IDX_IRQ_STATUS,
      IDX_IRQ_ENABLE,
      IDX_IRQ_CLEAR:   mapped = 1'b1;
      default:         mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [ETU_CNT_W-1:0] bgt_last(input logic t1);
    bgt_last = (t1 ? BGT_ETU_T1 : BGT_ETU_T0) - 1'b1;
  endfunction

  // ------------------------------------------------------------------
  // Receive queue
  // ------------------------------------------------------------------
  rx_queue #(
    .DEPTH      (QUEUE_DEPTH)
  ) u_rx_queue (
    .sys_clk_in (SYS_CLK_IN),
    .rst_in     (RST_IN),
    .q_if       (q_if)
  );

  assign q_if.depth_sel = q.depth_sel;
  assign q_if.push_data = RX_CHAR_IN;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    n     = q;
    idx   = PADDR_IN[APB_AW-1:2];
    setup = PSEL_IN & ~PENABLE_IN;
    done  = PSEL_IN & PENABLE_IN & q.pready;
    wr    = done & PWRITE_IN & ~q.pslverr;
    rd    = done & ~PWRITE_IN & ~q.pslverr;

    // Pins pass two flops; the third stage only feeds edge detection
    n.io_meta   = CARD_IO_IN;
    n.io_sync   = q.io_meta;
    n.io_prev   = q.io_sync;
    n.pres_meta = CARD_PRESENT_IN;
    n.pres_sync = q.pres_meta;

    // Read view of the status flags
    mixed             = '0;
    mixed[MS_CLOCK_SWITCH_DONE]   = q.clk_sw_done;
    mixed[MS_EMPTY]   = q_if.empty;
    mixed[MS_BGT]     = q.bgt_flag;
    mixed[MS_PRESENT] = q.pres_sync;
    mixed[MS_TXRX]    = q.txrx_flag;

    rd_val = '0;
    case (idx)
      IDX_MIXED_STATUS: rd_val = mixed;
      IDX_HOLDING:      rd_val = q_if.empty ? '0 : q_if.head_data;
      IDX_CONTROL: begin
        rd_val[CTL_RUN]    = q.run;
        rd_val[CTL_T1]     = q.t1;
        rd_val[CTL_LCT]    = q.last_char_transmit_mode;
        rd_val[CTL_CLKREQ] = q.clk_req;
      end
      IDX_IRQ_STATUS:   rd_val[IRQ_W-1:0] = q.irq_st;
      IDX_IRQ_ENABLE:   rd_val[IRQ_W-1:0] = q.irq_en;
      default:          rd_val = '0;
    endcase

    // No wait state: answer is prepared at the setup edge
    if (setup) begin
      n.pready  = 1'b1;
      n.pslverr = ~mapped(idx);
      n.rdata   = rd_val;
    end else if (done) begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
    end

    // Register writes
    wr_ctl = wr & (idx == IDX_CONTROL);
    wr_qc  = wr & (idx == IDX_QUEUE_CTRL);
    wr_tx  = wr & (idx == IDX_HOLDING);
    rd_rx  = rd & (idx == IDX_HOLDING);
    if (wr_ctl) begin
      n.run     = PWDATA_IN[CTL_RUN];
      n.t1      = PWDATA_IN[CTL_T1];
      n.last_char_transmit_mode     = PWDATA_IN[CTL_LCT];
      n.clk_req = PWDATA_IN[CTL_CLKREQ];
    end
    if (wr_qc) begin
      // Bits 7 and 3 are dropped; the register has no read path
      n.perr_limit = PWDATA_IN[QC_PEL_LSB +: QC_FIELD_W];
      n.depth_sel  = PWDATA_IN[QC_DEPTH_LSB +: QC_FIELD_W];
    end
    n.tx_load = wr_tx;
    if (wr_tx) begin
      n.tx_data = PWDATA_IN[CHAR_W-1:0];
    end
    run_fall = q.run & ~n.run;

    // Receive side: protocol zero drops bad characters and counts them
    store    = 1'b0;
    perr_hit = 1'b0;
    if (RX_VALID_IN) begin
      if (!RX_PARITY_ERR_IN) begin
        store = 1'b1;
        if (!q.t1) begin
          n.perr_cnt = '0;
        end
      end else if (q.t1) begin
        store    = 1'b1;
        perr_hit = 1'b1;
      end else if (q.perr_cnt == q.perr_limit) begin
        perr_hit   = 1'b1;
        n.perr_cnt = '0;
      end else begin
        n.perr_cnt = q.perr_cnt + 1'b1;
      end
    end
    // Rewriting the limit restarts the error count
    if (wr_qc) begin
      n.perr_cnt = '0;
    end
    overrun    = store & q_if.full;
    q_if.push  = store;
    q_if.pop   = rd_rx;
    q_if.flush = run_fall;

    // Event interrupts; the mixed status flags are kept out
    clr_mask = wr && (idx == IDX_IRQ_CLEAR) ? PWDATA_IN[IRQ_W-1:0] : '0;
    if (wr && (idx == IDX_IRQ_ENABLE)) begin
      n.irq_en = PWDATA_IN[IRQ_W-1:0];
    end
    n.irq_st              = q.irq_st & ~clr_mask;
    n.irq_st[IRQ_PARITY]  = n.irq_st[IRQ_PARITY] | perr_hit;
    n.irq_st[IRQ_OVERRUN] = n.irq_st[IRQ_OVERRUN] | overrun;
    n.irq                 = |(n.irq_st & n.irq_en);

    // Clock switch completion
    n.half_prev = CLK_HALF_ACTIVE_IN;
    if (CLK_HALF_ACTIVE_IN && !q.half_prev) begin
      n.clk_sw_done = 1'b1;
    end else if (!CLK_HALF_ACTIVE_IN && q.half_prev) begin
      n.clk_sw_done = 1'b0;
    end else if (run_fall) begin
      n.clk_sw_done = 1'b0;
    end

    // Transmit empty / receive full; a set beats a clear
    n.tx_mode_prev = TX_MODE_IN;
    n.full_prev    = q_if.full;
    txrx_set = (TX_MODE_IN & ~q.tx_mode_prev)
             | (TX_DONE_IN & ~(q.last_char_transmit_mode & TX_PARITY_OK_IN))
             | (q_if.full & ~q.full_prev);
    txrx_clr = run_fall | wr_tx | rd_rx
             | (~TX_MODE_IN & q.tx_mode_prev);
    if (txrx_set) begin
      n.txrx_flag = 1'b1;
    end else if (txrx_clr) begin
      n.txrx_flag = 1'b0;
    end

    // Start bits: falling I/O edges outside a character frame
    start_bit = q.io_prev & ~q.io_sync & ~q.in_frame;
    if (start_bit) begin
      n.in_frame  = 1'b1;
      n.frame_cnt = '0;
    end else if (q.in_frame && ETU_TICK_IN) begin
      if (q.frame_cnt == CHAR_ETU - 1'b1) begin
        n.in_frame = 1'b0;
      end else begin
        n.frame_cnt = q.frame_cnt + 1'b1;
      end
    end

    // Block guard counter restarts at every start bit
    if (start_bit) begin
      n.bgt_cnt  = '0;
      n.bgt_run  = 1'b1;
      n.bgt_flag = 1'b0;
    end else if (q.bgt_run && ETU_TICK_IN) begin
      if (q.bgt_cnt == bgt_last(q.t1)) begin
        n.bgt_flag = 1'b1;
        n.bgt_run  = 1'b0;
      end else begin
        n.bgt_cnt = q.bgt_cnt + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers and outputs
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign PRDATA_OUT         = {{(APB_DW-CHAR_W){1'b0}}, q.rdata};
  assign PREADY_OUT         = q.pready;
  assign PSLVERR_OUT        = q.pslverr;
  assign IRQ_OUT            = q.irq;
  assign TX_LOAD_OUT        = q.tx_load;
  assign TX_DATA_OUT        = q.tx_data;
  assign UART_RUN_OUT       = q.run;
  assign PROTOCOL_T1_OUT    = q.t1;
  assign LCT_MODE_OUT       = q.last_char_transmit_mode;
  assign CLK_SWITCH_REQ_OUT = q.clk_req;
endmodule

//--- design/rx_queue.sv
// Receive character queue with programmable depth
`timescale 1ns/10ps

module rx_queue #(
  parameter int unsigned DEPTH = card_uart_pkg::FIFO_DEPTH
) (
  input  wire logic   sys_clk_in,
  input  wire logic   rst_in,
  rx_queue_if.queue   q_if
);
  import card_uart_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);

  // The depth field can ask for every entry, so no other size serves
  if (DEPTH != (2 ** QC_FIELD_W)) begin : g_depth_check
    $error("rx_queue: DEPTH must equal two to the field width");
  end

  typedef struct packed {
    logic [DEPTH-1:0][CHAR_W-1:0] mem;
    logic [PW-1:0]                rd_ptr;
    logic [PW-1:0]                wr_ptr;
    logic [CNT_W-1:0]             count;
  } queue_t;

  queue_t q;
  queue_t n;
  logic   do_push;
  logic   do_pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign q_if.head_data = q.mem[q.rd_ptr];
  assign q_if.empty     = (q.count == '0);
  // Full once the count reaches the selected depth plus one
  assign q_if.full      = (q.count > {1'b0, q_if.depth_sel});

  always_comb begin
    n       = q;
    do_push = q_if.push & ~q_if.full;
    do_pop  = q_if.pop & ~q_if.empty;
    if (q_if.flush) begin
      n.rd_ptr = '0;
      n.wr_ptr = '0;
      n.count  = '0;
    end else begin
      if (do_push) begin
        n.mem[q.wr_ptr] = q_if.push_data;
        n.wr_ptr        = next_ptr(q.wr_ptr);
      end
      if (do_pop) begin
        n.rd_ptr = next_ptr(q.rd_ptr);
      end
      if (do_push && !do_pop) begin
        n.count = q.count + 1'b1;
      end else if (do_pop && !do_push) begin
        n.count = q.count - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

//--- dv/card_model.sv
// Behavioural smart card: presence contact and framed I/O line
`timescale 1ns/10ps

module card_model (
  input  wire logic clk_in,
  input  wire logic tick_in,
  input  wire logic send_in,
  input  wire logic insert_in,
  output logic      io_out,
  output logic      present_out
);
  logic [3:0] bit_n;
  logic       busy;
  // Idle line is pulled up; data bits alternate so that falling edges
  // occur inside the frame and must not pass for start bits
  initial begin
    io_out = 1'b1;
    busy   = 1'b0;
    bit_n  = 4'h0;
  end
  assign present_out = insert_in;
  always @(posedge clk_in) begin
    if (send_in) begin
      busy   <= 1'b1;
      bit_n  <= 4'h0;
      io_out <= 1'b0;
    end else if (busy && tick_in) begin
      bit_n  <= bit_n + 4'h1;
      io_out <= bit_n[0] || bit_n == 4'h9;
      busy   <= bit_n != 4'h9;
    end
  end
endmodule

//--- dv/card_uart_mixed_status_monitor.sv
// Port-level assertions for the card UART mixed status block
`timescale 1ns/10ps

module card_uart_mixed_status_monitor (
  input wire logic                             SYS_CLK_IN,
  input wire logic                             RST_IN,
  input wire logic                             PSEL_IN,
  input wire logic                             PENABLE_IN,
  input wire logic                             PWRITE_IN,
  input wire logic [card_uart_pkg::APB_AW-1:0] PADDR_IN,
  input wire logic [card_uart_pkg::APB_DW-1:0] PWDATA_IN,
  input wire logic [card_uart_pkg::APB_DW-1:0] PRDATA_OUT,
  input wire logic                             PREADY_OUT,
  input wire logic                             PSLVERR_OUT,
  input wire logic                             IRQ_OUT,
  input wire logic                             CARD_PRESENT_IN,
  input wire logic                             RX_VALID_IN,
  input wire logic                             TX_LOAD_OUT,
  input wire logic [card_uart_pkg::CHAR_W-1:0] TX_DATA_OUT,
  input wire logic                             UART_RUN_OUT,
  input wire logic                             PROTOCOL_T1_OUT,
  input wire logic                             LCT_MODE_OUT
);
  import card_uart_pkg::*;
  logic [IDX_W-1:0] idx;
  logic             done, mapped, ms_rd, pres_q;
  logic [2:0]       pres_cnt, cause_cnt;
  assign idx    = PADDR_IN[APB_AW-1:2];
  assign done   = PSEL_IN && PENABLE_IN && PREADY_OUT;
  assign ms_rd  = done && !PWRITE_IN && idx == IDX_MIXED_STATUS;
  assign mapped = idx inside {IDX_QUEUE_CTRL, IDX_HOLDING, IDX_CONTROL,
                              IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR};
  // Presence passes a synchroniser: only trust it once it has settled
  always_ff @(posedge SYS_CLK_IN) begin
    pres_q <= CARD_PRESENT_IN;
    if (RST_IN || pres_q != CARD_PRESENT_IN) pres_cnt <= '0;
    else if (pres_cnt != 3'h7) pres_cnt <= pres_cnt + 3'h1;
    if (RST_IN || RX_VALID_IN || (done && PWRITE_IN)) cause_cnt <= '0;
    else if (cause_cnt != 3'h7) cause_cnt <= cause_cnt + 3'h1;
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking dc @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  setup_ready_a: assert property (
    PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("no ready after setup");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  err_unmapped_a: assert property (
    PSEL_IN && !PENABLE_IN |=> PSLVERR_OUT == !$past(mapped))
    else $error("wrong error response");
  tx_load_a: assert property (
    done && PWRITE_IN && idx == IDX_HOLDING
    |=> TX_LOAD_OUT && TX_DATA_OUT == $past(PWDATA_IN[CHAR_W-1:0]))
    else $error("holding write not loaded");
  ctrl_write_a: assert property (
    done && PWRITE_IN && idx == IDX_CONTROL
    |=> UART_RUN_OUT == $past(PWDATA_IN[CTL_RUN])
        && PROTOCOL_T1_OUT == $past(PWDATA_IN[CTL_T1])
        && LCT_MODE_OUT == $past(PWDATA_IN[CTL_LCT]))
    else $error("control bits wrong");
  present_rd_a: assert property (
    ms_rd && pres_cnt == 3'h7 |-> PRDATA_OUT[MS_PRESENT] == CARD_PRESENT_IN)
    else $error("present bit wrong");
  ms_unused_a: assert property (
    ms_rd |-> PRDATA_OUT[APB_DW-1:8] == '0 && PRDATA_OUT[4:3] == 2'h0
              && !PRDATA_OUT[1])
    else $error("unused status bits set");
  irq_cause_a: assert property ($rose(IRQ_OUT) |-> cause_cnt < 3'h4)
    else $error("interrupt without cause");

  guard_seen_c: cover property (ms_rd && PRDATA_OUT[MS_BGT]);
  irq_seen_c: cover property ($rose(IRQ_OUT));
  err_seen_c: cover property (PSLVERR_OUT);
endmodule

//--- dv/card_uart_mixed_status_tb.sv
// Self-checking bench for the card UART mixed status block
`timescale 1ns/10ps

module card_uart_mixed_status_tb;
  import card_uart_pkg::*;
  logic        clk, rst, psel, pen, pwr, tick, send, ins, rxv, rxpe, txd;
  logic        txok, txm, half, io, pres, pready, pslverr, irq, tx_load;
  logic        run, t1, last_char_transmit_mode, creq, e_cs, e_em, e_bg, e_tx;
  logic [7:0]  paddr, rxc, txdata;
  logic [31:0] pwdata, prdata, seed;
  logic [32:0] notes[$];
  logic [7:0]  chq[$];
  int          num_errors, n_checks, lim[2], d;

  card_uart_mixed_status #(.QUEUE_DEPTH(FIFO_DEPTH)) uut (
    .SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .IRQ_OUT(irq), .ETU_TICK_IN(tick), .CARD_IO_IN(io),
    .CARD_PRESENT_IN(pres), .RX_VALID_IN(rxv), .RX_CHAR_IN(rxc),
    .RX_PARITY_ERR_IN(rxpe), .TX_DONE_IN(txd), .TX_PARITY_OK_IN(txok),
    .TX_MODE_IN(txm), .CLK_HALF_ACTIVE_IN(half), .TX_LOAD_OUT(tx_load),
    .TX_DATA_OUT(txdata), .UART_RUN_OUT(run), .PROTOCOL_T1_OUT(t1),
    .LCT_MODE_OUT(last_char_transmit_mode), .CLK_SWITCH_REQ_OUT(creq));
  card_model card (.clk_in(clk), .tick_in(tick), .send_in(send),
    .insert_in(ins), .io_out(io), .present_out(pres));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [31:0] ms();
    logic [31:0] v;
    v = 32'h0;
    v[MS_CLOCK_SWITCH_DONE] = e_cs;
    v[MS_EMPTY] = e_em;
    v[MS_BGT] = e_bg;
    v[MS_PRESENT] = ins;
    v[MS_TXRX] = e_tx;
    return v;
  endfunction
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Reads leave their expected answer for the watcher below
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dat, input logic e = 1'b0);
    int n;
    if (!w) notes.push_back({e, dat});
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    // Ready is sampled at the rising edge that completes the transfer
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 20);
    if (!pready) begin
      num_errors++;
      complete_run();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd_ms();
    apb(1'b0, 8'h30, ms());
  endtask
  task automatic chk_irq(input logic e);
    @(negedge clk);
    check({32'h0, irq}, {32'h0, e});
  endtask
  task automatic pulse_tx(input logic ok);
    @(posedge clk);
    txd <= 1'b1;
    txok <= ok;
    @(posedge clk);
    txd <= 1'b0;
    cyc(3);
  endtask
  task automatic push(input logic pe, input logic keep);
    logic [7:0] c;
    c = rnd8();
    if (keep) chq.push_back(c);
    @(posedge clk);
    rxv <= 1'b1;
    rxc <= c;
    rxpe <= pe;
    @(posedge clk);
    rxv <= 1'b0;
    cyc(3);
  endtask
  task automatic lvl(input logic is_mode, input logic v);
    @(posedge clk);
    if (is_mode) txm <= v;
    else half <= v;
    cyc(3);
  endtask
  task automatic etu(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      cyc(2);
    end
  endtask

  always @(posedge clk) begin
    if (psel && pen && pready && !pwr) begin
      if (notes.size() == 0) check(33'h0, 33'h1);
      else check({pslverr, prdata}, notes.pop_front());
    end
  end

  initial begin
    {psel, pen, pwr, tick, send, ins, rxv, rxpe, txd, txok, txm, half} = '0;
    {paddr, rxc, pwdata} = '0;
    {num_errors, n_checks, e_cs, e_bg, e_tx} = '0;
    e_em = 1'b1;
    seed = 32'd309;
    lim = '{int'(BGT_ETU_T1), int'(BGT_ETU_T0)};
    rst = 1'b1;
    cyc(3);
    rst <= 1'b0;
    rd_ms();
    apb(1'b0, 8'h50, 32'h0, 1'b1);
    apb(1'b1, 8'h40, 32'h1);
    push(1'b0, 1'b1);
    {e_em, e_tx} = 2'b01;
    rd_ms();
    apb(1'b0, 8'h34, {24'h0, chq.pop_front()});
    {e_em, e_tx} = 2'b10;
    rd_ms();
    ins <= 1'b1;
    cyc(6);
    rd_ms();
    $display("test reset and presence done");
    apb(1'b1, 8'h40, 32'h9);
    apb(1'b0, 8'h40, 32'h9);
    check({32'h0, creq}, 33'h1);
    lvl(1'b0, 1'b1);
    e_cs = 1'b1;
    rd_ms();
    apb(1'b1, 8'h40, 32'h1);
    lvl(1'b0, 1'b0);
    e_cs = 1'b0;
    rd_ms();
    lvl(1'b0, 1'b1);
    apb(1'b1, 8'h40, 32'h0);
    rd_ms();
    lvl(1'b0, 1'b0);
    apb(1'b1, 8'h40, 32'h1);
    $display("test clock switch done");
    apb(1'b1, 8'h48, 32'h3);
    lvl(1'b1, 1'b1);
    e_tx = 1'b1;
    rd_ms();
    chk_irq(1'b0);
    apb(1'b1, 8'h34, {24'h0, rnd8()});
    e_tx = 1'b0;
    rd_ms();
    pulse_tx(1'b1);
    e_tx = 1'b1;
    rd_ms();
    apb(1'b1, 8'h34, {24'h0, rnd8()});
    apb(1'b1, 8'h40, 32'h5);
    pulse_tx(1'b1);
    e_tx = 1'b0;
    rd_ms();
    pulse_tx(1'b0);
    e_tx = 1'b1;
    rd_ms();
    lvl(1'b1, 1'b0);
    e_tx = 1'b0;
    rd_ms();
    lvl(1'b1, 1'b1);
    apb(1'b1, 8'h40, 32'h0);
    rd_ms();
    lvl(1'b1, 1'b0);
    apb(1'b1, 8'h40, 32'h1);
    $display("test tx empty flag done");
    foreach (lim[i]) begin
      d = i ? FIFO_DEPTH : 3;
      apb(1'b1, 8'h30, d - 1);
      repeat (d - 1) push(1'b0, 1'b1);
      e_em = 1'b0;
      rd_ms();
      push(1'b0, 1'b1);
      e_tx = 1'b1;
      rd_ms();
      push(1'b0, 1'b0);
      apb(1'b0, 8'h44, 32'h2);
      chk_irq(1'b1);
      apb(1'b1, 8'h48, 32'h0);
      chk_irq(1'b0);
      apb(1'b1, 8'h48, 32'h3);
      apb(1'b1, 8'h4C, 32'h2);
      chk_irq(1'b0);
      repeat (d) apb(1'b0, 8'h34, {24'h0, chq.pop_front()});
      {e_em, e_tx} = 2'b10;
      rd_ms();
    end
    $display("test queue depth done");
    apb(1'b1, 8'h30, 32'h20);
    repeat (2) push(1'b1, 1'b0);
    chk_irq(1'b0);
    push(1'b1, 1'b0);
    chk_irq(1'b1);
    apb(1'b0, 8'h44, 32'h1);
    apb(1'b1, 8'h4C, 32'h1);
    chk_irq(1'b0);
    rd_ms();
    $display("test parity limit done");
    foreach (lim[i]) begin
      apb(1'b1, 8'h40, i ? 32'h1 : 32'h3);
      @(posedge clk);
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      cyc(6);
      e_bg = 1'b0;
      etu(lim[i] - 1);
      rd_ms();
      etu(1);
      e_bg = 1'b1;
      rd_ms();
    end
    $display("test block guard done");
    lvl(1'b1, 1'b1);
    lvl(1'b0, 1'b1);
    {e_cs, e_tx} = 2'b11;
    rd_ms();
    // Inputs drop while reset is held, so no false edge follows it
    rst <= 1'b1;
    {txm, half} <= 2'b00;
    cyc(3);
    rst <= 1'b0;
    cyc(4);
    {e_cs, e_bg, e_tx} = '0;
    rd_ms();
    $display("test mid-run reset done");
    cyc(5);
    complete_run();
  end
endmodule

bind card_uart_mixed_status card_uart_mixed_status_monitor mon (.*);
